// file: rtl/dpc_pkg.sv
/*
  Constants for the pixel correction host port: control and status
  field positions, threshold widths, frame limits, reset values.
  Assumes inclusion before any design file that imports it.
*/
package dpc_pkg;
  // -------------------------------------------------------------------
  // control and status layout
  // -------------------------------------------------------------------
  localparam int CTRL_W = 2;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_DONE_BIT = 1;
  localparam int STAT_W = 8;
  localparam int STAT_EMPTY_BIT = 0;
  localparam int STAT_FULL_BIT = 1;
  localparam int STAT_LOCK_BIT = 7;
  localparam logic [STAT_W-1:0] STAT_RESET = 8'h00;
  // -------------------------------------------------------------------
  // thresholds and frame limits
  // -------------------------------------------------------------------
  localparam int SPATIAL_W = 16;
  localparam int AGE_W = 16;
  localparam int DEF_DATA_W = 8;
  localparam int MAX_COLS = 4096;
  localparam int MAX_ROWS = 4096;
  localparam longint MAX_PIXELS = 64'(MAX_COLS) * 64'(MAX_ROWS);
  localparam int COUNT_W = $clog2(MAX_PIXELS + 1);
  localparam logic [SPATIAL_W-1:0] SPATIAL_RESET = 16'h0000;
  localparam logic [AGE_W-1:0] AGE_RESET = 16'h0000;
  localparam logic CTRL_ENABLE_RESET = 1'b0;
endpackage

// file: rtl/dpc_frame_counter.sv
/*
  Per-frame event counter: counts single-cycle events during a frame,
  publishes the total at the frame boundary and holds it a whole frame.
  Assumes event and boundary pulses come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dpc_frame_counter #(
  parameter int WIDTH = 25
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_sclr,
  input wire logic i_event,
  input wire logic i_frame_end,
  output logic [WIDTH-1:0] o_count
);
  localparam logic [WIDTH-1:0] CNT_MAX = {WIDTH{1'b1}};
  localparam logic [WIDTH-1:0] CNT_ZERO = '0;
  localparam logic [WIDTH-1:0] CNT_ONE = {{(WIDTH-1){1'b0}}, 1'b1};

  logic [WIDTH-1:0] run_q;
  logic [WIDTH-1:0] run_d;
  logic [WIDTH-1:0] out_q;
  logic [WIDTH-1:0] out_d;
  logic [WIDTH-1:0] run_inc;

  // -------------------------------------------------------------------
  // running count, saturating
  // -------------------------------------------------------------------
  always_comb begin
    run_inc = run_q;
    if (i_event && run_q != CNT_MAX) begin
      run_inc = run_q + CNT_ONE;
    end
    run_d = run_inc;
    out_d = out_q;
    if (i_sclr) begin
      run_d = CNT_ZERO;
      out_d = CNT_ZERO;
    end else if (i_frame_end) begin
      // boundary-cycle event belongs to the ending frame
      out_d = run_inc;
      run_d = CNT_ZERO;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      run_q <= '0;
      out_q <= '0;
    end else begin
      run_q <= run_d;
      out_q <= out_d;
    end
  end

  assign o_count = out_q;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  a_count_publish: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    i_frame_end && !i_sclr && run_q != CNT_MAX
    |=> o_count == $past(run_q) + ($past(i_event) ? CNT_ONE : CNT_ZERO)
        && run_q == CNT_ZERO)
    else $error("frame count not published correctly");
  a_count_saturate: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    run_q == CNT_MAX && !i_sclr && !i_frame_end |=> run_q == CNT_MAX)
    else $error("frame counter wrapped");
endmodule
`default_nettype wire

// file: rtl/dpc_host_port.sv
/*
  Host parameter and status port of the defective pixel correction
  core, port variant: control, thresholds in; status and per-frame
  counts out. Internal second register stage loads the thresholds on vblank rise with the done bit set; the enable bit is registered every cycle.
  Assumes an outside shadow register bank drives the threshold and
  control ports, and the datapath signals share i_mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module dpc_host_port #(
  parameter int DATA_WIDTH = dpc_pkg::DEF_DATA_W,
  parameter int MAX_COLS = dpc_pkg::MAX_COLS,
  parameter int MAX_ROWS = dpc_pkg::MAX_ROWS,
  parameter int STATUS_WIDTH = dpc_pkg::COUNT_W
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_sclr,
  input wire logic i_vblank,
  input wire logic [dpc_pkg::CTRL_W-1:0] i_host_control,
  input wire logic [DATA_WIDTH-1:0] i_temporal_thresh,
  input wire logic [dpc_pkg::SPATIAL_W-1:0] i_spatial_thresh,
  input wire logic [dpc_pkg::AGE_W-1:0] i_age_thresh,
  input wire logic i_fifo_empty,
  input wire logic i_fifo_full,
  input wire logic i_timing_locked,
  input wire logic i_cand_stored,
  input wire logic i_pixel_replaced,
  output logic o_corr_enable,
  output logic [DATA_WIDTH-1:0] o_work_temporal,
  output logic [dpc_pkg::SPATIAL_W-1:0] o_work_spatial,
  output logic [dpc_pkg::AGE_W-1:0] o_work_age,
  output logic o_frame_start,
  output logic [dpc_pkg::STAT_W-1:0] o_core_status_flags,
  output logic [STATUS_WIDTH-1:0] o_num_candidates,
  output logic [STATUS_WIDTH-1:0] o_num_defective
);
  import dpc_pkg::*;

  localparam logic [DATA_WIDTH-1:0] TEMPORAL_RESET = '0;

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  logic vblank_q;
  logic vblank_d;
  logic vblank_rise;
  logic enable_q;
  logic enable_d;
  logic [DATA_WIDTH-1:0] temporal_q;
  logic [DATA_WIDTH-1:0] temporal_d;
  logic [SPATIAL_W-1:0] spatial_q;
  logic [SPATIAL_W-1:0] spatial_d;
  logic [AGE_W-1:0] age_q;
  logic [AGE_W-1:0] age_d;
  logic [STAT_W-1:0] status_q;
  logic [STAT_W-1:0] status_d;
  logic start_q;
  logic start_d;

  assign vblank_rise = i_vblank && !vblank_q;

  // -------------------------------------------------------------------
  // control and working thresholds
  // -------------------------------------------------------------------
  always_comb begin
    vblank_d = i_vblank;
    enable_d = i_host_control[CTRL_ENABLE_BIT];
    temporal_d = temporal_q;
    spatial_d = spatial_q;
    age_d = age_q;
    start_d = vblank_rise;
    if (i_sclr) begin
      vblank_d = 1'b0;
      enable_d = CTRL_ENABLE_RESET;
      temporal_d = TEMPORAL_RESET;
      spatial_d = SPATIAL_RESET;
      age_d = AGE_RESET;
      start_d = 1'b0;
    end else if (vblank_rise && i_host_control[CTRL_DONE_BIT]) begin
      // copy only a finished shadow update, never a half-written one
      temporal_d = i_temporal_thresh;
      spatial_d = i_spatial_thresh;
      age_d = i_age_thresh;
    end
    // done bit low: previous working values carry into next frame
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      vblank_q <= 1'b0;
      enable_q <= CTRL_ENABLE_RESET;
      temporal_q <= TEMPORAL_RESET;
      spatial_q <= SPATIAL_RESET;
      age_q <= AGE_RESET;
      start_q <= 1'b0;
    end else begin
      vblank_q <= vblank_d;
      enable_q <= enable_d;
      temporal_q <= temporal_d;
      spatial_q <= spatial_d;
      age_q <= age_d;
      start_q <= start_d;
    end
  end

  // -------------------------------------------------------------------
  // status flags
  // -------------------------------------------------------------------
  always_comb begin
    status_d = STAT_RESET;
    status_d[STAT_EMPTY_BIT] = i_fifo_empty;
    status_d[STAT_FULL_BIT] = i_fifo_full;
    status_d[STAT_LOCK_BIT] = i_timing_locked;
    if (i_sclr) begin
      status_d = STAT_RESET;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      status_q <= STAT_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // -------------------------------------------------------------------
  // per-frame counts
  // -------------------------------------------------------------------
  dpc_frame_counter #(
    .WIDTH(STATUS_WIDTH)
  ) u_cand_count (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_sclr(i_sclr),
    .i_event(i_cand_stored),
    .i_frame_end(vblank_rise),
    .o_count(o_num_candidates)
  );

  dpc_frame_counter #(
    .WIDTH(STATUS_WIDTH)
  ) u_defect_count (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_sclr(i_sclr),
    .i_event(i_pixel_replaced),
    .i_frame_end(vblank_rise),
    .o_count(o_num_defective)
  );

  assign o_corr_enable = enable_q;
  assign o_work_temporal = temporal_q;
  assign o_work_spatial = spatial_q;
  assign o_work_age = age_q;
  assign o_frame_start = start_q;
  assign o_core_status_flags = status_q;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);

  a_width_legal: assert property (
    DATA_WIDTH == 8 || DATA_WIDTH == 10 || DATA_WIDTH == 12)
    else $error("sample width must be 8, 10 or 12");

  a_count_room: assert property (
    STATUS_WIDTH >= $clog2(64'(MAX_COLS) * 64'(MAX_ROWS) + 1)
    && MAX_COLS <= 4096 && MAX_ROWS <= 4096)
    else $error("count width too small for frame size");

  a_enable_follow: assert property (
    !i_sclr |=> o_corr_enable == $past(i_host_control[0]))
    else $error("enable does not follow control bit 0");

  a_spatial_load: assert property (
    vblank_rise && i_host_control[1] && !i_sclr
    |=> o_work_spatial == $past(i_spatial_thresh)
        && o_work_age == $past(i_age_thresh))
    else $error("spatial or age threshold not loaded");

  a_temporal_load: assert property (
    vblank_rise && i_host_control[1] && !i_sclr
    |=> o_work_temporal == $past(i_temporal_thresh))
    else $error("temporal threshold not loaded");

  a_hold_undone: assert property (
    vblank_rise && !i_host_control[1] && !i_sclr
    |=> $stable(o_work_spatial) && $stable(o_work_age)
        && $stable(o_work_temporal))
    else $error("thresholds changed without done bit");

  a_hold_midframe: assert property (
    !vblank_rise && !i_sclr
    |=> $stable(o_work_spatial) && $stable(o_work_temporal)
        && $stable(o_work_age))
    else $error("thresholds changed outside vblank rise");

  a_status_map: assert property (
    !i_sclr |=> o_core_status_flags[0] == $past(i_fifo_empty)
    && o_core_status_flags[1] == $past(i_fifo_full)
    && o_core_status_flags[7] == $past(i_timing_locked)
    && o_core_status_flags[6:2] == 5'h00)
    else $error("status flag mapping wrong");

  a_counts_steady: assert property (
    !vblank_rise && !i_sclr
    |=> $stable(o_num_candidates) && $stable(o_num_defective))
    else $error("frame counts changed mid frame");

  a_frame_pulse: assert property (
    vblank_rise && !i_sclr |=> o_frame_start ##1 !o_frame_start)
    else $error("frame start pulse wrong");

  c_load_done: cover property (vblank_rise && i_host_control[1]);
  c_load_skip: cover property (vblank_rise && !i_host_control[1]);
  c_count_frame: cover property (
    i_cand_stored && i_pixel_replaced ##[1:50] vblank_rise);
  c_fifo_full: cover property (o_core_status_flags[1]);
endmodule
`default_nettype wire

// file: tb/dpc_host_bank.sv
/*
  Host side shadow register bank for the pixel correction port.
  Assumes the bench calls its tasks; values change at falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module dpc_host_bank (
  input wire logic i_mclk,
  output logic [dpc_pkg::CTRL_W-1:0] o_host_control,
  output logic [dpc_pkg::DEF_DATA_W-1:0] o_temporal,
  output logic [dpc_pkg::SPATIAL_W-1:0] o_spatial,
  output logic [dpc_pkg::AGE_W-1:0] o_age
);
  import dpc_pkg::*;
  // ------------------------------------------------------------
  // shadow registers
  // ------------------------------------------------------------
  initial begin
    o_host_control = 2'h2;
    o_temporal = 8'h00;
    o_spatial = 16'h0000;
    o_age = 16'h0000;
  end
  // writes one field a cycle with semaphore low, then raises it if done is set
  task automatic update(input logic [7:0] t, input logic [15:0] s,
                        input logic [15:0] a, input logic done);
    @(negedge i_mclk) o_host_control[1] = 1'b0;
    @(negedge i_mclk) o_temporal = t;
    @(negedge i_mclk) o_spatial = s;
    @(negedge i_mclk) o_age = a;
    if (done) begin
      @(negedge i_mclk) o_host_control[1] = 1'b1;
    end
  endtask
  task automatic finish();
    @(negedge i_mclk) o_host_control[1] = 1'b1;
  endtask
  task automatic set_enable(input logic en);
    @(negedge i_mclk) o_host_control[0] = en;
  endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
/*
  Self-checking bench for dpc_host_port, one task per scenario.
  Assumes dpc_pkg and dpc_host_bank are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dpc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, sclr = 1'b0, vb = 1'b0;
  logic emp = 1'b0, ful = 1'b0, lck = 1'b0, cand = 1'b0, rep = 1'b0;
  logic [CTRL_W-1:0] ctl;
  logic [7:0] tt, wt, st;
  logic [15:0] ts, ta, ws, wa;
  logic en, fs;
  logic [COUNT_W-1:0] nc, nd;
  int n_fail = 0, comparisons = 0, carry = 0;
  // ------------------------------------------------------------
  // structure
  // ------------------------------------------------------------
  always #5 clk = ~clk;
  dpc_host_bank host (.i_mclk(clk), .o_host_control(ctl),
    .o_temporal(tt), .o_spatial(ts), .o_age(ta));
  dpc_host_port #(.DATA_WIDTH(8)) dut (.i_mclk(clk), .i_sys_rst(rst),
    .i_sclr(sclr), .i_vblank(vb), .i_host_control(ctl),
    .i_temporal_thresh(tt), .i_spatial_thresh(ts), .i_age_thresh(ta),
    .i_fifo_empty(emp), .i_fifo_full(ful), .i_timing_locked(lck),
    .i_cand_stored(cand), .i_pixel_replaced(rep), .o_corr_enable(en),
    .o_work_temporal(wt), .o_work_spatial(ws), .o_work_age(wa),
    .o_frame_start(fs), .o_core_status_flags(st),
    .o_num_candidates(nc), .o_num_defective(nd));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic results();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic rise();
    @(negedge clk) vb = 1'b1;
    @(negedge clk) chk("frame_start", 1, 32'(fs));
    @(negedge clk) vb = 1'b0;
    chk("frame_start_end", 0, 32'(fs));
  endtask
  task automatic work(input logic [7:0] t, input logic [15:0] s, a);
    chk("work_temporal", 32'(t), 32'(wt));
    chk("work_spatial", 32'(s), 32'(ws));
    chk("work_age", 32'(a), 32'(wa));
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_load();
    host.update(8'h5a, 16'h1234, 16'h00c3, 1'b1);
    work(8'h00, 16'h0000, 16'h0000);
    rise();
    work(8'h5a, 16'h1234, 16'h00c3);
  endtask
  task automatic t_hold();
    host.update(8'hff, 16'hffff, 16'h8001, 1'b0);
    rise();
    work(8'h5a, 16'h1234, 16'h00c3);
    host.finish();
    repeat (2) @(negedge clk);
    work(8'h5a, 16'h1234, 16'h00c3);
    rise();
    work(8'hff, 16'hffff, 16'h8001);
  endtask
  task automatic t_enable();
    for (int v = 1; v >= 0; v--) begin
      host.set_enable(v[0]);
      @(negedge clk) chk("corr_enable", 32'(v), 32'(en));
    end
  endtask
  task automatic t_status();
    for (int i = 0; i < 8; i++) begin
      @(negedge clk) {lck, ful, emp} = i[2:0];
      @(negedge clk) chk("status", {i[2], 5'h0, i[1:0]}, 32'(st));
    end
  endtask
  task automatic t_count(input int a, b);
    for (int i = 0; i < 6; i++) begin
      @(negedge clk) cand = (i < a);
      rep = (i < b);
    end
    @(negedge clk) cand = 1'b0;
    rep = 1'b0;
    rise();
    chk("num_candidates", 32'(a + carry), 32'(nc));
    chk("num_defective", 32'(b + carry), 32'(nd));
    repeat (3) begin
      @(negedge clk) cand = 1'b1;
      rep = 1'b1;
    end
    @(negedge clk) cand = 1'b0;
    rep = 1'b0;
    chk("cand_hold", 32'(a + carry), 32'(nc));
    chk("defect_hold", 32'(b + carry), 32'(nd));
    carry = 3;
  endtask
  task automatic t_sclr();
    @(negedge clk) sclr = 1'b1;
    @(negedge clk) sclr = 1'b0;
    work(8'h00, 16'h0000, 16'h0000);
    chk("sclr_status", 0, 32'(st));
    chk("sclr_count", 0, 32'(nc));
    chk("sclr_defect", 0, 32'(nd));
    chk("sclr_frame_start", 0, 32'(fs));
  endtask
  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    chk("reset_status", 0, 32'(st));
    work(8'h00, 16'h0000, 16'h0000);
    t_load();
    t_hold();
    t_enable();
    t_status();
    t_count(6, 2);
    t_count(0, 5);
    t_sclr();
    results();
  end
  initial begin
    #100000;
    n_fail++;
    results();
  end
endmodule
`default_nettype wire
